// ### src/sosc_top.sv
`timescale 1ns/1ns
`default_nettype none
module sosc_top
  import sosc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire sosc_req_t req,
  output logic [15:0] reg_rdata,
  input wire logic [NCH-1:0] channel_operation_enable,
  output logic [NCH-1:0] channel_stop_trigger,
  input wire logic [NOUT-1:0] comm_data,
  input wire logic [NOUT-1:0] comm_data_upd,
  input wire logic [NOUT-1:0] comm_clock,
  input wire logic [NOUT-1:0] comm_clock_upd,
  output logic [NOUT-1:0] serial_data_pin,
  output logic [NOUT-1:0] serial_clock_pin,
  input wire sosc_wake_t wake,
  output logic [1:0] receive_done_irq,
  output logic [1:0] receive_error_irq,
  output logic [1:0] wake_flag_hold
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [NOUT-1:0] data_output_bit;
  logic [NOUT-1:0] clock_output_bit;
  logic [NOUT-1:0] channel_output_enable;
  logic [NOUT-1:0] level_inversion_bit;
  logic [1:0] wake_reception_enable;
  logic [1:0] wake_error_irq_suppress;
  logic [NOUT-1:0] next_data, next_clock, next_oen, next_inv, next_pin;
  logic [NCH-1:0] next_stop;
  logic [1:0] next_wake_en, next_wake_supp;
  logic [1:0] next_done_irq, next_err_irq;
  logic [15:0] next_rdata;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  wire wr_full = req.wr && !req.byte_lo;
  wire hit_stop0 = req.addr == ADDR_STOP0;
  wire hit_stop1 = req.addr == ADDR_STOP1;
  wire [1:0] hit_lvl = {req.addr == ADDR_LVL1, req.addr == ADDR_LVL0};
  wire [1:0] hit_oen = {req.addr == ADDR_OEN1, req.addr == ADDR_OEN0};
  wire [1:0] hit_inv = {req.addr == ADDR_INV1, req.addr == ADDR_INV0};
  wire [1:0] hit_wake = {req.addr == ADDR_WAKE1, req.addr == ADDR_WAKE0};

  // Stop triggers are one-cycle pulses; nothing is stored behind them
  assign next_stop = req.wr ?
    ({hit_stop1 ? req.wdata[1:0] : 2'h0,
      hit_stop0 ? req.wdata[3:0] : 4'h0}) : 6'h00;

  // ---------------------------------------------------------------
  // Per-channel output bits
  // ---------------------------------------------------------------
  genvar k;
  generate
    for (k = 0; k < NOUT; k++) begin : g_out
      localparam int P = OUT_POS[k];
      localparam int U = OUT_UNIT[k];
      wire sw_data = req.wr && hit_lvl[U];
      wire sw_clock = wr_full && hit_lvl[U];
      wire enabled = channel_operation_enable[OUT_SE[k]];
      // Locked bits silently drop software writes
      assign next_data[k] = (sw_data && !channel_output_enable[k]) ?
        req.wdata[P] : (channel_output_enable[k] && comm_data_upd[k]) ?
        comm_data[k] : data_output_bit[k];
      assign next_clock[k] = (sw_clock && !enabled) ?
        req.wdata[CKO_OFS+P] : (enabled && comm_clock_upd[k]) ?
        comm_clock[k] : clock_output_bit[k];
      assign next_oen[k] = (req.wr && hit_oen[U]) ?
        req.wdata[P] : channel_output_enable[k];
      assign next_inv[k] = (req.wr && hit_inv[U]) ?
        req.wdata[P] : level_inversion_bit[k];
      // Inversion only matters while the engine owns the pin
      assign next_pin[k] = channel_output_enable[k] ?
        (data_output_bit[k] ^ level_inversion_bit[k]) :
        data_output_bit[k];
    end
  endgenerate

  // ---------------------------------------------------------------
  // Wake control and interrupt routing
  // ---------------------------------------------------------------
  assign next_wake_en = {
    (req.wr && hit_wake[1]) ? req.wdata[WAKE_EN_POS] :
      wake_reception_enable[1],
    (req.wr && hit_wake[0]) ? req.wdata[WAKE_EN_POS] :
      wake_reception_enable[0]};
  assign next_wake_supp = {
    (req.wr && hit_wake[1]) ? req.wdata[WAKE_SUPP_POS] :
      wake_error_irq_suppress[1],
    (req.wr && hit_wake[0]) ? req.wdata[WAKE_SUPP_POS] :
      wake_error_irq_suppress[0]};
  // Suppression is only honoured while wake reception is armed
  wire [1:0] supp_act = wake_error_irq_suppress & wake_reception_enable;
  assign next_done_irq = wake.rx_done |
    (wake.rx_err & ~wake.eoc_sel);
  assign next_err_irq = wake.rx_err & wake.eoc_sel & ~supp_act;

  // ---------------------------------------------------------------
  // Read data; fixed ones are returned so readback matches reset
  // ---------------------------------------------------------------
  wire [15:0] lvl0_word = {4'h0, 1'b1, clock_output_bit[1], 1'b1,
    clock_output_bit[0], 4'h0, 1'b1, data_output_bit[1], 1'b1,
    data_output_bit[0]};
  wire [15:0] lvl1_word = {6'h00, 1'b1, clock_output_bit[2], 6'h00,
    1'b1, data_output_bit[2]};
  wire [15:0] oen0_word = {13'h0000, channel_output_enable[1], 1'b0,
    channel_output_enable[0]};
  wire [15:0] oen1_word = {15'h0000, channel_output_enable[2]};
  wire [15:0] inv0_word = {13'h0000, level_inversion_bit[1], 1'b0,
    level_inversion_bit[0]};
  wire [15:0] inv1_word = {15'h0000, level_inversion_bit[2]};
  wire [15:0] wake0_word = {14'h0000, wake_error_irq_suppress[0],
    wake_reception_enable[0]};
  wire [15:0] wake1_word = {14'h0000, wake_error_irq_suppress[1],
    wake_reception_enable[1]};
  // Stop triggers and unmapped addresses read zero
  assign next_rdata = !req.rd ? reg_rdata :
    hit_lvl[0] ? lvl0_word : hit_lvl[1] ? lvl1_word :
    hit_oen[0] ? oen0_word : hit_oen[1] ? oen1_word :
    hit_inv[0] ? inv0_word : hit_inv[1] ? inv1_word :
    hit_wake[0] ? wake0_word : hit_wake[1] ? wake1_word :
    ZERO_RST;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Stored control state
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      data_output_bit <= {LVL1_RST[OUT_POS[2]], LVL0_RST[OUT_POS[1]],
        LVL0_RST[OUT_POS[0]]};
      clock_output_bit <= {LVL1_RST[CKO_OFS], LVL0_RST[CKO_OFS+2],
        LVL0_RST[CKO_OFS]};
      channel_output_enable <= ZERO_RST[NOUT-1:0];
      level_inversion_bit <= ZERO_RST[NOUT-1:0];
      wake_reception_enable <= ZERO_RST[1:0];
      wake_error_irq_suppress <= ZERO_RST[1:0];
    end else begin
      data_output_bit <= next_data;
      clock_output_bit <= next_clock;
      channel_output_enable <= next_oen;
      level_inversion_bit <= next_inv;
      wake_reception_enable <= next_wake_en;
      wake_error_irq_suppress <= next_wake_supp;
    end
  end

  // Outputs, all straight from flops; stop leaves the bits alone
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata <= ZERO_RST;
      channel_stop_trigger <= ZERO_RST[NCH-1:0];
      serial_data_pin <= OUT_RST;
      serial_clock_pin <= OUT_RST;
      receive_done_irq <= ZERO_RST[1:0];
      receive_error_irq <= ZERO_RST[1:0];
      wake_flag_hold <= ZERO_RST[1:0];
    end else begin
      reg_rdata <= next_rdata;
      channel_stop_trigger <= next_stop;
      serial_data_pin <= next_pin;
      serial_clock_pin <= clock_output_bit;
      receive_done_irq <= next_done_irq;
      receive_error_irq <= next_err_irq;
      wake_flag_hold <= wake_reception_enable;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_stop0_write;
    req.wr && hit_stop0 && req.wdata[0];
  endsequence
  // A second stop write straight after the first may keep the pulse up
  sequence s_stop_pulse;
    channel_stop_trigger[0] ##1 (!channel_stop_trigger[0] ||
      $past(req.wr && hit_stop0 && req.wdata[0]));
  endsequence

  property p_stop_pulse;
    @(posedge core_clk) disable iff (!rst_n)
      s_stop0_write |=> s_stop_pulse;
  endproperty
  a_stop_pulse: assert property (p_stop_pulse)
    else $error("stop trigger pulse missing");

  property p_stop_read_zero;
    @(posedge core_clk) disable iff (!rst_n)
      req.rd && (hit_stop0 || hit_stop1) |=> reg_rdata == 16'h0000;
  endproperty
  a_stop_read_zero: assert property (p_stop_read_zero)
    else $error("stop trigger read not zero");

  property p_data_locked;
    @(posedge core_clk) disable iff (!rst_n)
      channel_output_enable[0] && req.wr && hit_lvl[0] &&
      !comm_data_upd[0] |=> $stable(data_output_bit[0]);
  endproperty
  a_data_locked: assert property (p_data_locked)
    else $error("data bit changed by software while enabled");

  property p_clock_locked;
    @(posedge core_clk) disable iff (!rst_n)
      channel_operation_enable[0] && req.wr && hit_lvl[0] &&
      !comm_clock_upd[0] |=> $stable(clock_output_bit[0]);
  endproperty
  a_clock_locked: assert property (p_clock_locked)
    else $error("clock bit changed by software while running");

  property p_pin_level;
    @(posedge core_clk) disable iff (!rst_n)
      channel_output_enable[1] && level_inversion_bit[1] ##1 1'b1
      |-> serial_data_pin[1] == !$past(data_output_bit[1]);
  endproperty
  a_pin_level: assert property (p_pin_level)
    else $error("inverted pin level wrong");

  property p_pin_plain;
    @(posedge core_clk) disable iff (!rst_n)
      !channel_output_enable[0] |=>
      serial_data_pin[0] == $past(data_output_bit[0]) &&
      serial_clock_pin[0] == $past(clock_output_bit[0]);
  endproperty
  a_pin_plain: assert property (p_pin_plain)
    else $error("pin does not follow output bits");

  property p_lvl_fixed;
    @(posedge core_clk) disable iff (!rst_n)
      req.rd && hit_lvl[0] |=> reg_rdata[15:12] == 4'h0 &&
      reg_rdata[11] && reg_rdata[9] && reg_rdata[3] && reg_rdata[1];
  endproperty
  a_lvl_fixed: assert property (p_lvl_fixed)
    else $error("fixed level bits read wrong");

  property p_oen_unused;
    @(posedge core_clk) disable iff (!rst_n)
      req.rd && hit_oen[0] |=> reg_rdata[15:3] == 13'h0000 &&
      !reg_rdata[1];
  endproperty
  a_oen_unused: assert property (p_oen_unused)
    else $error("unused output enable bit reads one");

  property p_err_suppressed;
    @(posedge core_clk) disable iff (!rst_n)
      wake.rx_err[0] && wake.eoc_sel[0] && supp_act[0] |=>
      !receive_error_irq[0] &&
      (!receive_done_irq[0] || $past(wake.rx_done[0]));
  endproperty
  a_err_suppressed: assert property (p_err_suppressed)
    else $error("suppressed error raised an interrupt");

  property p_done_irq;
    @(posedge core_clk) disable iff (!rst_n)
      wake.rx_done[1] |=> receive_done_irq[1];
  endproperty
  a_done_irq: assert property (p_done_irq)
    else $error("receive interrupt missing");

endmodule
`default_nettype wire

// ### src/sosc_pkg.sv
package sosc_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [19:0] ADDR_STOP0 = 20'hf0124;
  localparam logic [19:0] ADDR_LVL0 = 20'hf0128;
  localparam logic [19:0] ADDR_OEN0 = 20'hf012a;
  localparam logic [19:0] ADDR_INV0 = 20'hf0134;
  localparam logic [19:0] ADDR_WAKE0 = 20'hf0138;
  localparam logic [19:0] ADDR_STOP1 = 20'hf0164;
  localparam logic [19:0] ADDR_LVL1 = 20'hf0168;
  localparam logic [19:0] ADDR_OEN1 = 20'hf016a;
  localparam logic [19:0] ADDR_INV1 = 20'hf0174;
  localparam logic [19:0] ADDR_WAKE1 = 20'hf0178;

  // ---------------------------------------------------------------
  // Fields and reset values
  // ---------------------------------------------------------------
  localparam int CKO_OFS = 8;
  localparam int WAKE_EN_POS = 0;
  localparam int WAKE_SUPP_POS = 1;
  localparam logic [15:0] LVL0_RST = 16'h0f0f;
  localparam logic [15:0] LVL1_RST = 16'h0303;
  localparam logic [15:0] ZERO_RST = 16'h0000;
  localparam logic [2:0] OUT_RST = 3'h7;
  // Output channels: unit0 ch0, unit0 ch2, unit1 ch0
  localparam int NOUT = 3;
  localparam int NCH = 6;
  localparam int OUT_POS [0:2] = '{0, 2, 0};
  localparam int OUT_UNIT [0:2] = '{0, 0, 1};
  localparam int OUT_SE [0:2] = '{0, 2, 4};

  // Register port request
  typedef struct packed {
    logic [19:0] addr;
    logic wr;
    logic byte_lo;
    logic rd;
    logic [15:0] wdata;
  } sosc_req_t;

  // Per-unit wake reception events
  typedef struct packed {
    logic [1:0] rx_done;
    logic [1:0] rx_err;
    logic [1:0] eoc_sel;
  } sosc_wake_t;

endpackage

// ### bench/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  import sosc_pkg::*;
  // ---------------------------------------------------------------
  // Stimulus, model state and counters
  // ---------------------------------------------------------------
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  sosc_req_t req = '0;
  sosc_wake_t wake = '0;
  logic [NCH-1:0] chan_en = '0;
  logic [NCH-1:0] stop_pulse;
  logic [NCH-1:0] stop_or = '0;
  logic [NOUT-1:0] cd = '0, cdu = '0, cc = '0, ccu = '0, dpin, cpin;
  logic [15:0] reg_rdata;
  logic [15:0] lf = 16'h0042;
  logic [15:0] d;
  logic [1:0] done_irq, err_irq, hold;
  int n_fail = 0;
  int check_count = 0;
  int n_stop = 0, exp_stop = 0, b0, b1;
  int n_done [2] = '{0, 0};
  int n_err [2] = '{0, 0};
  // Implemented level bits kept apart from the fixed ones, which always read 1
  int m_imp [2] = '{16'h0505, 16'h0101};
  int m_fix [2] = '{16'h0a0a, 16'h0202};
  int m_lvl [2] = '{16'h0505, 16'h0101};
  int m_oen [2] = '{0, 0};
  int m_inv [2] = '{0, 0};
  int m_wake [2] = '{0, 0};
  localparam logic [19:0] RA [4][2] = '{'{ADDR_LVL0, ADDR_LVL1},
    '{ADDR_OEN0, ADDR_OEN1}, '{ADDR_INV0, ADDR_INV1}, '{ADDR_WAKE0, ADDR_WAKE1}};
  localparam logic [19:0] AD [11] = '{ADDR_STOP0, ADDR_LVL0, ADDR_OEN0,
    ADDR_INV0, ADDR_WAKE0, ADDR_STOP1, ADDR_LVL1, ADDR_OEN1, ADDR_INV1,
    ADDR_WAKE1, 20'hf0130};

  sosc_top u_sosc_top (.core_clk(core_clk), .rst_n(rst_n), .req(req),
    .reg_rdata(reg_rdata), .channel_operation_enable(chan_en),
    .channel_stop_trigger(stop_pulse), .comm_data(cd), .comm_data_upd(cdu),
    .comm_clock(cc), .comm_clock_upd(ccu), .serial_data_pin(dpin),
    .serial_clock_pin(cpin), .wake(wake), .receive_done_irq(done_irq),
    .receive_error_irq(err_irq), .wake_flag_hold(hold));

  // Free-running clock, 4 ns period
  initial begin
    forever #2 core_clk = ~core_clk;
  end

  // Pulse outputs are summed, so a stuck or doubled pulse shows as a count
  always @(negedge core_clk) begin
    if (rst_n) begin
      n_stop += $countones(stop_pulse);
      stop_or |= stop_pulse;
      for (int u = 0; u < 2; u++) begin
        n_done[u] += done_irq[u];
        n_err[u] += err_irq[u];
      end
    end
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  function automatic logic [15:0] mexp(input logic [19:0] a);
    int u;
    u = (a >= 20'hf0160) ? 1 : 0;
    if (a == RA[0][u]) return 16'(m_lvl[u] | m_fix[u]);
    if (a == RA[1][u]) return 16'(m_oen[u]);
    if (a == RA[2][u]) return 16'(m_inv[u]);
    if (a == RA[3][u]) return 16'(m_wake[u]);
    return 16'h0000;
  endfunction

  task automatic chk(input string nm, input logic [15:0] seen,
      input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results;
    if (n_fail == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Write, updating the model with the same drop conditions as the port
  task automatic wr(input logic [19:0] a, input logic [15:0] dv,
      input logic bl);
    int u, p;
    u = (a >= 20'hf0160) ? 1 : 0;
    @(negedge core_clk);
    req <= {a, 1'b1, bl, 1'b0, dv};
    if (a == ADDR_STOP0 || a == ADDR_STOP1)
      exp_stop += $countones(dv & (u ? 16'h0003 : 16'h000f));
    if (a == RA[1][u]) m_oen[u] = dv & m_imp[u] & 16'h00ff;
    if (a == RA[2][u]) m_inv[u] = dv & m_imp[u] & 16'h00ff;
    if (a == RA[3][u]) m_wake[u] = dv & 16'h0003;
    for (int k = 0; k < NOUT; k++) begin
      p = OUT_POS[k];
      if (a == RA[0][u] && OUT_UNIT[k] == u) begin
        if (!m_oen[u][p]) m_lvl[u][p] = dv[p];
        if (!bl && !chan_en[OUT_SE[k]]) m_lvl[u][p+8] = dv[p+8];
      end
    end
    @(negedge core_clk);
    req <= '0;
  endtask

  task automatic rchk(input logic [19:0] a);
    @(negedge core_clk);
    req <= {a, 3'b001, 16'h0000};
    @(negedge core_clk);
    req <= '0;
    @(negedge core_clk);
    chk("register read", reg_rdata, mexp(a));
  endtask

  task automatic comm(input int k, input logic dv, input logic cv);
    @(negedge core_clk);
    {cd[k], cdu[k], cc[k], ccu[k]} <= {dv, 1'b1, cv, 1'b1};
    // The engine only reaches a bit that it owns at that moment
    if (m_oen[OUT_UNIT[k]][OUT_POS[k]])
      m_lvl[OUT_UNIT[k]][OUT_POS[k]] = dv;
    if (chan_en[OUT_SE[k]])
      m_lvl[OUT_UNIT[k]][OUT_POS[k]+8] = cv;
    @(negedge core_clk);
    {cdu, ccu} <= '0;
  endtask

  task automatic pchk;
    logic [NOUT-1:0] ed, ec;
    int u, p;
    repeat (3) @(negedge core_clk);
    for (int k = 0; k < NOUT; k++) begin
      u = OUT_UNIT[k];
      p = OUT_POS[k];
      ed[k] = m_lvl[u][p] ^ (m_oen[u][p] & m_inv[u][p]);
      ec[k] = m_lvl[u][p+8];
    end
    chk("data pins", 16'(dpin), 16'(ed));
    chk("clock pins", 16'(cpin), 16'(ec));
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(negedge core_clk);
    rst_n <= 1'b1;
    foreach (AD[i]) rchk(AD[i]);
    pchk;
    wr(ADDR_STOP0, 16'h000f, 1'b0);
    wr(ADDR_STOP1, 16'h0002, 1'b0);
    wr(ADDR_STOP0, 16'h0000, 1'b0);
    repeat (3) @(negedge core_clk);
    chk("stop pulses", 16'(n_stop), 16'(exp_stop));
    chk("stop bits", 16'(stop_or), 16'h002f);
    rchk(ADDR_STOP0);
    pchk;
    // Software shaping with outputs disabled, then with channels enabled
    wr(ADDR_LVL0, 16'h0a0a, 1'b0);
    pchk;
    chan_en <= 6'h3f;
    wr(ADDR_LVL0, 16'h0f0f, 1'b0);
    wr(ADDR_LVL1, 16'h0202, 1'b0);
    pchk;
    rchk(ADDR_LVL0);
    chan_en <= 6'h00;
    wr(ADDR_LVL0, 16'h0a0a, 1'b1);
    rchk(ADDR_LVL0);
    wr(ADDR_INV0, 16'h0005, 1'b0);
    wr(ADDR_INV1, 16'h0001, 1'b0);
    pchk;
    wr(ADDR_OEN0, 16'h0005, 1'b0);
    wr(ADDR_OEN1, 16'h0001, 1'b0);
    chan_en <= 6'h3f;
    wr(ADDR_LVL0, 16'h0f0f, 1'b0);
    rchk(ADDR_LVL0);
    for (int k = 0; k < NOUT; k++) comm(k, 1'(k), 1'b0);
    pchk;
    // Random traffic; inversion is only rewritten on stopped channels
    for (int i = 0; i < 60; i++) begin
      lf = lfsr(lf);
      d = lfsr(lf ^ 16'h5a5a);
      @(negedge core_clk);
      chan_en <= (lf[2:1] == 2'h2) ? lf[8:3] & (lf[0] ? 6'h0f : 6'h30)
        : lf[8:3];
      if (lf[2:1] == 2'h3) comm(lf[10:9] % 3, d[0], d[1]);
      else if (lf[2:1] == 2'h0)
        wr(RA[0][lf[0]], 16'((d & m_imp[lf[0]]) | m_fix[lf[0]]), lf[11]);
      else wr(RA[lf[2:1]][lf[0]], 16'(d & m_imp[lf[0]] & 16'h00ff), 1'b0);
      pchk;
      rchk(RA[lf[2:1] % 3][lf[0]]);
    end
    // Mid-run reset must bring every register back to its reset value
    rst_n <= 1'b0;
    repeat (2) @(negedge core_clk);
    rst_n <= 1'b1;
    m_lvl = m_imp;
    m_oen = '{0, 0};
    m_inv = '{0, 0};
    foreach (AD[i]) rchk(AD[i]);
    pchk;
    // Wake reception interrupt routing over every permitted setting
    for (int u = 0; u < 2; u++) begin
      for (int w = 0; w < 4; w++) begin
        for (int e = 0; e < 2; e++) begin
          if (w != 2 && !(w == 3 && e == 0)) begin
            wr(RA[3][u], 16'(w), 1'b0);
            rchk(RA[3][u]);
            @(negedge core_clk);
            wake.eoc_sel[u] <= e[0];
            b0 = n_done[u];
            b1 = n_err[u];
            @(negedge core_clk);
            wake.rx_done[u] <= 1'b1;
            @(negedge core_clk);
            {wake.rx_done[u], wake.rx_err[u]} <= 2'b01;
            @(negedge core_clk);
            wake.rx_err[u] <= 1'b0;
            repeat (2) @(negedge core_clk);
            chk("done irq", 16'(n_done[u] - b0), 16'(1 + (e == 0)));
            chk("error irq", 16'(n_err[u] - b1), 16'(e == 1 && w != 3));
            chk("wake hold", 16'(hold[u]), 16'(w & 1));
          end
        end
      end
      wr(RA[3][u], 16'h0000, 1'b0);
    end
    results;
  end

  // Hang guard at 50000 cycles, well beyond the fewer than a thousand cycles the run needs
  initial begin
    #200000;
    n_fail++;
    results;
  end
endmodule
`default_nettype wire
